/* core/tx_vga_gain_state_registers.sv */
// Gain-state register bank and per-state analog setting selection
//
// Function
// RULE1: Amp one on by control bit, tx high
// RULE2: State 00 tx-on code, six bits, reset 3F
// RULE3: State 00 tx-off code, six bits, reset 3F
// RULE4: Code maps monotonically, 0 to 31.5 dB
// RULE5: Codes 31 and 32 give equal attenuation
// RULE6: Up to 31 stage two; above adds one
// RULE7: Bias trims amp two high, one low
// RULE8: Amp one linearity trim, resets zero
// RULE9: Amp two linearity trim, resets five
// RULE10: Manual first stage code, resets zero
// RULE11: Manual second stage code, resets zero
// RULE12: Amp two linearity off, states 11/10/01
// RULE13: Amp one linearity off, states 11/10
// RULE14: Manual bit picks manual stage codes
// RULE15: States 01/10/11 own attenuation codes
// RULE16: Amp one linearity off, state 01
// RULE17: Controller holds transmit enable high normally
// RULE18: Reserved bits read zero, ignore writes; path_ctrl stores and reads back bits 3 and 4
// RULE19: Select pins pick state, outputs track
`timescale 1ns/100ps
`default_nettype none
`include "tx_vga_defs.svh"

module tx_vga_gain_state_registers #(
   parameter int ADDR_W = 15,
   parameter int DATA_W = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   input wire logic transmit_enable_pin,
   input wire logic [1:0] atten_state_select_pins,
   output logic first_amp_on,
   output logic second_amp_on,
   output logic bias_gen_on,
   output logic [4:0] first_attenuator_stage,
   output logic [4:0] second_attenuator_stage,
   output logic [3:0] first_amp_bias_trim,
   output logic [3:0] second_amp_bias_trim,
   output logic [4:0] first_amp_linearity_code,
   output logic [4:0] second_amp_linearity_code,
   output logic first_amp_lin_off,
   output logic second_amp_lin_off
);

   // ****************************************
   // Serial port
   // ****************************************
   logic wr_en;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] wr_data;
   logic [DATA_W-1:0] read_data, next_read_data;

   spi_reg_port #(
      .ADDR_W(ADDR_W),
      .DATA_W(DATA_W)
   ) u_port (
      .clk(clk),
      .reset(reset),
      .spi_cs_n(spi_cs_n),
      .spi_sclk(spi_sclk),
      .spi_sdi(spi_sdi),
      .rd_data(read_data),
      .spi_sdo(spi_sdo),
      .spi_sdo_oe(spi_sdo_oe),
      .wr_en(wr_en),
      .reg_addr(reg_addr),
      .wr_data(wr_data)
   );

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic txen_meta, txen_sync;
   logic [1:0] sel_meta, sel_sync;

   always_ff @(posedge clk) begin
      if (reset) begin
         txen_meta <= 1'b0;
         txen_sync <= 1'b0;
         sel_meta <= 2'h0;
         sel_sync <= 2'h0;
      end else begin
         txen_meta <= transmit_enable_pin;
         txen_sync <= txen_meta;
         sel_meta <= atten_state_select_pins;
         sel_sync <= sel_meta;
      end
   end

   // ****************************************
   // Register file
   // ****************************************
   logic [7:0] path_ctrl, next_path_ctrl;
   tx_vga_pkg::atten_code_t atten_tx_on [4];
   tx_vga_pkg::atten_code_t next_atten_tx_on [4];
   tx_vga_pkg::atten_code_t state0_atten_tx_off, next_state0_atten_tx_off;
   logic [7:0] bias_trim [4];
   logic [7:0] next_bias_trim [4];
   tx_vga_pkg::stage_code_t first_amp_linearity_trim, next_first_amp_linearity_trim;
   tx_vga_pkg::stage_code_t second_amp_linearity_trim, next_second_amp_linearity_trim;
   tx_vga_pkg::stage_code_t first_stage_manual_atten, next_first_stage_manual_atten;
   tx_vga_pkg::stage_code_t second_stage_manual_atten, next_second_stage_manual_atten;
   logic [7:0] per_state_linearity_off, next_per_state_linearity_off;

   always_comb begin
      next_path_ctrl = path_ctrl;
      next_atten_tx_on = atten_tx_on;
      next_state0_atten_tx_off = state0_atten_tx_off;
      next_bias_trim = bias_trim;
      next_first_amp_linearity_trim = first_amp_linearity_trim;
      next_second_amp_linearity_trim = second_amp_linearity_trim;
      next_first_stage_manual_atten = first_stage_manual_atten;
      next_second_stage_manual_atten = second_stage_manual_atten;
      next_per_state_linearity_off = per_state_linearity_off;
      // Only field bits are stored, except path_ctrl, which keeps all eight bits; other reserved bits drop on write [RULE18]
      if (wr_en) begin
         case (reg_addr)
            `ADDR_PATH_CTRL: next_path_ctrl = wr_data; // [RULE1] [RULE14]
            `ADDR_STATE0_ATTEN_TX_ON: next_atten_tx_on[0] = wr_data[5:0]; // [RULE2]
            `ADDR_STATE0_ATTEN_TX_OFF: next_state0_atten_tx_off = wr_data[5:0]; // [RULE3]
            `ADDR_STATE0_BIAS_REF_TRIM: next_bias_trim[0] = wr_data; // [RULE7]
            `ADDR_FIRST_AMP_LIN_TRIM: next_first_amp_linearity_trim = wr_data[4:0]; // [RULE8]
            `ADDR_SECOND_AMP_LIN_TRIM: next_second_amp_linearity_trim = wr_data[4:0]; // [RULE9]
            `ADDR_FIRST_STAGE_MANUAL: next_first_stage_manual_atten = wr_data[4:0]; // [RULE10]
            `ADDR_SECOND_STAGE_MANUAL: next_second_stage_manual_atten = wr_data[4:0]; // [RULE11]
            `ADDR_PER_STATE_LIN_OFF: begin
               next_per_state_linearity_off = wr_data & `LIN_OFF_WRITE_MASK; // [RULE12] [RULE13] [RULE16]
            end
            `ADDR_STATE1_BIAS_REF_TRIM: next_bias_trim[1] = wr_data;
            `ADDR_STATE2_BIAS_REF_TRIM: next_bias_trim[2] = wr_data;
            `ADDR_STATE3_BIAS_REF_TRIM: next_bias_trim[3] = wr_data;
            `ADDR_STATE1_ATTEN: next_atten_tx_on[1] = wr_data[5:0]; // [RULE15]
            `ADDR_STATE2_ATTEN: next_atten_tx_on[2] = wr_data[5:0]; // [RULE15]
            `ADDR_STATE3_ATTEN: next_atten_tx_on[3] = wr_data[5:0]; // [RULE15]
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         path_ctrl <= `RST_PATH_CTRL; // [RULE1]
         atten_tx_on[0] <= `RST_STATE0_ATTEN; // [RULE2]
         atten_tx_on[1] <= `RST_STATE1_ATTEN;
         atten_tx_on[2] <= `RST_STATE2_ATTEN;
         atten_tx_on[3] <= `RST_STATE3_ATTEN;
         state0_atten_tx_off <= `RST_STATE0_ATTEN; // [RULE3]
         for (int i = 0; i < 4; i++) begin
            bias_trim[i] <= `RST_BIAS_REF_TRIM; // [RULE7]
         end
         first_amp_linearity_trim <= `RST_FIRST_AMP_LIN_TRIM; // [RULE8]
         second_amp_linearity_trim <= `RST_SECOND_AMP_LIN_TRIM; // [RULE9]
         first_stage_manual_atten <= `RST_MANUAL_ATTEN; // [RULE10]
         second_stage_manual_atten <= `RST_MANUAL_ATTEN; // [RULE11]
         per_state_linearity_off <= `RST_PER_STATE_LIN_OFF; // [RULE12] [RULE13]
      end else begin
         path_ctrl <= next_path_ctrl;
         atten_tx_on <= next_atten_tx_on;
         state0_atten_tx_off <= next_state0_atten_tx_off;
         bias_trim <= next_bias_trim;
         first_amp_linearity_trim <= next_first_amp_linearity_trim;
         second_amp_linearity_trim <= next_second_amp_linearity_trim;
         first_stage_manual_atten <= next_first_stage_manual_atten;
         second_stage_manual_atten <= next_second_stage_manual_atten;
         per_state_linearity_off <= next_per_state_linearity_off;
      end
   end

   // ****************************************
   // Read-back
   // ****************************************
   // Registered so the port samples a stable byte; unmapped addresses read zero
   always_comb begin
      next_read_data = 8'h00;
      case (reg_addr)
         `ADDR_PATH_CTRL: next_read_data = path_ctrl;
         `ADDR_STATE0_ATTEN_TX_ON: next_read_data = {2'b00, atten_tx_on[0]}; // [RULE18]
         `ADDR_STATE0_ATTEN_TX_OFF: next_read_data = {2'b00, state0_atten_tx_off};
         `ADDR_STATE0_BIAS_REF_TRIM: next_read_data = bias_trim[0];
         `ADDR_FIRST_AMP_LIN_TRIM: next_read_data = {3'b000, first_amp_linearity_trim};
         `ADDR_SECOND_AMP_LIN_TRIM: next_read_data = {3'b000, second_amp_linearity_trim};
         `ADDR_FIRST_STAGE_MANUAL: next_read_data = {3'b000, first_stage_manual_atten};
         `ADDR_SECOND_STAGE_MANUAL: next_read_data = {3'b000, second_stage_manual_atten};
         `ADDR_PER_STATE_LIN_OFF: next_read_data = per_state_linearity_off;
         `ADDR_STATE1_BIAS_REF_TRIM: next_read_data = bias_trim[1];
         `ADDR_STATE2_BIAS_REF_TRIM: next_read_data = bias_trim[2];
         `ADDR_STATE3_BIAS_REF_TRIM: next_read_data = bias_trim[3];
         `ADDR_STATE1_ATTEN: next_read_data = {2'b00, atten_tx_on[1]};
         `ADDR_STATE2_ATTEN: next_read_data = {2'b00, atten_tx_on[2]};
         `ADDR_STATE3_ATTEN: next_read_data = {2'b00, atten_tx_on[3]};
         default: next_read_data = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         read_data <= 8'h00;
      end else begin
         read_data <= next_read_data;
      end
   end

   // ****************************************
   // Applied analog settings
   // ****************************************
   // Below 32: stage two alone; 32 up: stage two full,
   // rest in stage one, so 31 and 32 give the same
   function automatic logic [9:0] split_code(input tx_vga_pkg::atten_code_t code);
      tx_vga_pkg::atten_code_t remainder;
      remainder = code - `BOUNDARY_CODE;
      if (code < `BOUNDARY_CODE) begin
         split_code = {5'h00, code[4:0]}; // [RULE4] [RULE6]
      end else begin
         split_code = {remainder[4:0], `STAGE_FULL_CODE}; // [RULE5] [RULE6]
      end
   endfunction

   logic next_first_amp_on, next_second_amp_on, next_bias_gen_on;
   logic [4:0] next_first_stage, next_second_stage;
   logic [3:0] next_first_bias, next_second_bias;
   logic [4:0] next_first_lin, next_second_lin;
   logic next_first_lin_off, next_second_lin_off;

   always_comb begin
      logic [9:0] split;
      tx_vga_pkg::select_state_t sel;
      split = 10'h000;
      sel = sel_sync; // [RULE19]
      next_first_amp_on = txen_sync & path_ctrl[`CTRL_FIRST_AMP_BIT]; // [RULE1]
      next_second_amp_on = txen_sync & path_ctrl[`CTRL_SECOND_AMP_BIT];
      next_bias_gen_on = txen_sync & path_ctrl[`CTRL_BIAS_GEN_BIT];
      next_first_bias = bias_trim[sel][3:0]; // [RULE7] [RULE19]
      next_second_bias = bias_trim[sel][7:4]; // [RULE7]
      // Linearity trims only while transmitting
      next_first_lin = txen_sync ? first_amp_linearity_trim : 5'h00; // [RULE8]
      next_second_lin = txen_sync ? second_amp_linearity_trim : 5'h00; // [RULE9]
      case (sel)
         2'b00: begin
            next_first_lin_off = path_ctrl[`CTRL_FIRST_LIN_OFF_BIT];
            next_second_lin_off = path_ctrl[`CTRL_SECOND_LIN_OFF_BIT];
         end
         2'b01: begin
            next_first_lin_off = per_state_linearity_off[`LIN_OFF_FIRST_BASE]; // [RULE16]
            next_second_lin_off = per_state_linearity_off[`LIN_OFF_SECOND_BASE]; // [RULE12]
         end
         2'b10: begin
            next_first_lin_off = per_state_linearity_off[`LIN_OFF_FIRST_BASE + 1]; // [RULE13]
            next_second_lin_off = per_state_linearity_off[`LIN_OFF_SECOND_BASE + 1]; // [RULE12]
         end
         default: begin
            next_first_lin_off = per_state_linearity_off[`LIN_OFF_FIRST_BASE + 2]; // [RULE13]
            next_second_lin_off = per_state_linearity_off[`LIN_OFF_SECOND_BASE + 2]; // [RULE12]
         end
      endcase
      if (!txen_sync) begin
         // Transmit off: alternate code for every state
         split = split_code(state0_atten_tx_off); // [RULE3] [RULE17]
         next_first_lin_off = 1'b0;
         next_second_lin_off = 1'b0;
      end else if (path_ctrl[`CTRL_MANUAL_BIT]) begin
         split = {first_stage_manual_atten, second_stage_manual_atten}; // [RULE14] [RULE10] [RULE11]
      end else begin
         split = split_code(atten_tx_on[sel]); // [RULE2] [RULE15] [RULE19]
      end
      next_first_stage = split[9:5];
      next_second_stage = split[4:0];
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         first_amp_on <= 1'b0;
         second_amp_on <= 1'b0;
         bias_gen_on <= 1'b0;
         first_attenuator_stage <= 5'h00;
         second_attenuator_stage <= 5'h00;
         first_amp_bias_trim <= 4'h0;
         second_amp_bias_trim <= 4'h0;
         first_amp_linearity_code <= 5'h00;
         second_amp_linearity_code <= 5'h00;
         first_amp_lin_off <= 1'b0;
         second_amp_lin_off <= 1'b0;
      end else begin
         first_amp_on <= next_first_amp_on;
         second_amp_on <= next_second_amp_on;
         bias_gen_on <= next_bias_gen_on;
         first_attenuator_stage <= next_first_stage;
         second_attenuator_stage <= next_second_stage;
         first_amp_bias_trim <= next_first_bias;
         second_amp_bias_trim <= next_second_bias;
         first_amp_linearity_code <= next_first_lin;
         second_amp_linearity_code <= next_second_lin;
         first_amp_lin_off <= next_first_lin_off;
         second_amp_lin_off <= next_second_lin_off;
      end
   end

endmodule
`default_nettype wire

/* core/tx_vga_defs.svh */
// Offsets, fields, reset values and frame counts of the gain-state registers
`ifndef TX_VGA_DEFS_SVH
`define TX_VGA_DEFS_SVH

// ****************************************
// Register offsets (15-bit serial address)
// ****************************************
`define ADDR_PATH_CTRL 15'h0100
`define ADDR_STATE0_ATTEN_TX_ON 15'h0102
`define ADDR_STATE0_ATTEN_TX_OFF 15'h0103
`define ADDR_STATE0_BIAS_REF_TRIM 15'h0104
`define ADDR_FIRST_AMP_LIN_TRIM 15'h0105
`define ADDR_SECOND_AMP_LIN_TRIM 15'h0106
`define ADDR_FIRST_STAGE_MANUAL 15'h010A
`define ADDR_SECOND_STAGE_MANUAL 15'h010B
`define ADDR_PER_STATE_LIN_OFF 15'h0110
`define ADDR_STATE1_BIAS_REF_TRIM 15'h0111
`define ADDR_STATE2_BIAS_REF_TRIM 15'h0112
`define ADDR_STATE3_BIAS_REF_TRIM 15'h0113
`define ADDR_STATE1_ATTEN 15'h0114
`define ADDR_STATE2_ATTEN 15'h0115
`define ADDR_STATE3_ATTEN 15'h0116

// ****************************************
// Reset values
// ****************************************
`define RST_PATH_CTRL 8'h07
`define RST_STATE0_ATTEN 6'h3F
`define RST_BIAS_REF_TRIM 8'h55
`define RST_FIRST_AMP_LIN_TRIM 5'h00
`define RST_SECOND_AMP_LIN_TRIM 5'h05
`define RST_MANUAL_ATTEN 5'h00
`define RST_PER_STATE_LIN_OFF 8'h00
`define RST_STATE1_ATTEN 6'h18
`define RST_STATE2_ATTEN 6'h30
`define RST_STATE3_ATTEN 6'h3F

// ****************************************
// Field positions and masks
// ****************************************
`define CTRL_MANUAL_BIT 7
`define CTRL_SECOND_LIN_OFF_BIT 6
`define CTRL_FIRST_LIN_OFF_BIT 5
`define CTRL_BIAS_GEN_BIT 2
`define CTRL_SECOND_AMP_BIT 1
`define CTRL_FIRST_AMP_BIT 0
`define LIN_OFF_SECOND_BASE 4
`define LIN_OFF_FIRST_BASE 0
`define LIN_OFF_WRITE_MASK 8'h77
`define BOUNDARY_CODE 6'h20
`define STAGE_FULL_CODE 5'h1F

// ****************************************
// Serial frame counts
// ****************************************
`define SPI_LAST_INSTR_BIT 5'h0F
`define SPI_FIRST_DATA_BIT 5'h10
`define SPI_LAST_DATA_BIT 5'h17
`define SPI_FRAME_DONE 5'h18

`endif

/* core/tx_vga_pkg.sv */
// Types shared by the gain-state register block
package tx_vga_pkg;
   typedef logic [5:0] atten_code_t;
   typedef logic [4:0] stage_code_t;
   typedef logic [1:0] select_state_t;
endpackage

/* core/spi_reg_port.sv */
// Serial register port: read flag, 15-bit address, data byte
`timescale 1ns/100ps
`default_nettype none
`include "tx_vga_defs.svh"

module spi_reg_port #(
   parameter int ADDR_W = 15,
   parameter int DATA_W = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_sdi,
   input wire logic [DATA_W-1:0] rd_data,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   output logic wr_en,
   output logic [ADDR_W-1:0] reg_addr,
   output logic [DATA_W-1:0] wr_data
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic cs_meta, cs_sync, sclk_meta, sclk_sync, sclk_prev, sdi_meta, sdi_sync;

   always_ff @(posedge clk) begin
      if (reset) begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         sclk_meta <= 1'b0;
         sclk_sync <= 1'b0;
         sclk_prev <= 1'b0;
         sdi_meta <= 1'b0;
         sdi_sync <= 1'b0;
      end else begin
         cs_meta <= spi_cs_n;
         cs_sync <= cs_meta;
         sclk_meta <= spi_sclk;
         sclk_sync <= sclk_meta;
         sclk_prev <= sclk_sync;
         sdi_meta <= spi_sdi;
         sdi_sync <= sdi_meta;
      end
   end

   // ****************************************
   // Frame engine
   // ****************************************
   logic sclk_rise, sclk_fall;
   logic [4:0] bit_count, next_bit_count;
   logic [15:0] instr_shift, next_instr_shift;
   logic [DATA_W-1:0] data_shift, next_data_shift;
   logic [DATA_W-1:0] sdo_shift, next_sdo_shift;
   logic read_flag, next_read_flag;
   logic next_sdo, next_sdo_oe, next_wr_en;
   logic [ADDR_W-1:0] next_reg_addr;
   logic [DATA_W-1:0] next_wr_data;

   assign sclk_rise = sclk_sync & ~sclk_prev;
   assign sclk_fall = ~sclk_sync & sclk_prev;

   always_comb begin
      next_bit_count = bit_count;
      next_instr_shift = instr_shift;
      next_data_shift = data_shift;
      next_sdo_shift = sdo_shift;
      next_read_flag = read_flag;
      next_sdo = spi_sdo;
      next_sdo_oe = spi_sdo_oe;
      next_wr_en = 1'b0;
      next_reg_addr = reg_addr;
      next_wr_data = wr_data;
      if (cs_sync) begin
         // Deselect aborts any partial frame; a short write never lands
         next_bit_count = 5'h00;
         next_sdo_oe = 1'b0;
         next_read_flag = 1'b0;
      end else begin
         if (sclk_rise && bit_count != `SPI_FRAME_DONE) begin
            next_bit_count = bit_count + 5'h01;
            if (bit_count <= `SPI_LAST_INSTR_BIT) begin
               next_instr_shift = {instr_shift[14:0], sdi_sync};
               if (bit_count == `SPI_LAST_INSTR_BIT) begin
                  next_reg_addr = ADDR_W'({instr_shift[13:0], sdi_sync});
                  next_read_flag = instr_shift[14];
               end
            end else begin
               next_data_shift = {data_shift[DATA_W-2:0], sdi_sync};
               if (bit_count == `SPI_LAST_DATA_BIT && !read_flag) begin
                  next_wr_en = 1'b1;
                  next_wr_data = {data_shift[DATA_W-2:0], sdi_sync};
               end
            end
         end
         if (sclk_fall && read_flag) begin
            if (bit_count == `SPI_FIRST_DATA_BIT) begin
               next_sdo = rd_data[DATA_W-1];
               next_sdo_shift = {rd_data[DATA_W-2:0], 1'b0};
               next_sdo_oe = 1'b1;
            end else if (bit_count > `SPI_FIRST_DATA_BIT && bit_count < `SPI_FRAME_DONE) begin
               next_sdo = sdo_shift[DATA_W-1];
               next_sdo_shift = {sdo_shift[DATA_W-2:0], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         bit_count <= 5'h00;
         instr_shift <= 16'h0000;
         data_shift <= '0;
         sdo_shift <= '0;
         read_flag <= 1'b0;
         spi_sdo <= 1'b0;
         spi_sdo_oe <= 1'b0;
         wr_en <= 1'b0;
         reg_addr <= '0;
         wr_data <= '0;
      end else begin
         bit_count <= next_bit_count;
         instr_shift <= next_instr_shift;
         data_shift <= next_data_shift;
         sdo_shift <= next_sdo_shift;
         read_flag <= next_read_flag;
         spi_sdo <= next_sdo;
         spi_sdo_oe <= next_sdo_oe;
         wr_en <= next_wr_en;
         reg_addr <= next_reg_addr;
         wr_data <= next_wr_data;
      end
   end

endmodule
`default_nettype wire

/* testbench/tx_vga_gain_state_registers_chk.sv */
// Port checker of the gain-state register block
`timescale 1ns/100ps
`default_nettype none
module tx_vga_chk (
   input wire logic clk,
   input wire logic reset,
   input wire logic spi_cs_n,
   input wire logic spi_sdo_oe,
   input wire logic transmit_enable_pin,
   input wire logic [1:0] atten_state_select_pins,
   input wire logic first_amp_on,
   input wire logic second_amp_on,
   input wire logic bias_gen_on,
   input wire logic [4:0] first_attenuator_stage,
   input wire logic [4:0] second_attenuator_stage,
   input wire logic [3:0] first_amp_bias_trim,
   input wire logic [3:0] second_amp_bias_trim,
   input wire logic [4:0] first_amp_linearity_code,
   input wire logic [4:0] second_amp_linearity_code,
   input wire logic first_amp_lin_off,
   input wire logic second_amp_lin_off
);
   logic [2:0] up;
   always_ff @(posedge clk) begin
      if (reset)
         up <= 3'h0;
      else if (up != 3'h7)
         up <= up + 3'h1;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // Two sync stages plus the output flop: three edges of lag
   sequence tx_held_low;
      !transmit_enable_pin [*3];
   endsequence
   sequence quiet;
      (up == 3'h7 && spi_cs_n && $stable(transmit_enable_pin)
       && $stable(atten_state_select_pins)) [*8];
   endsequence
   chk_amp_gate: assert property (!transmit_enable_pin |-> ##3 !(first_amp_on | second_amp_on | bias_gen_on))
      else $error("amp on, tx off");
   // Bench keeps the control enable bits set
   chk_amp_follow: assert property ((up == 3'h7 && transmit_enable_pin) [*4] |-> first_amp_on && second_amp_on && bias_gen_on)
      else $error("amp off, tx on");
   chk_lin_gate: assert property (!transmit_enable_pin |-> ##3 (first_amp_linearity_code | second_amp_linearity_code) == 5'h00)
      else $error("lin code while tx off");
   chk_linoff_gate: assert property (!transmit_enable_pin |-> ##3 !first_amp_lin_off && !second_amp_lin_off)
      else $error("lin off while tx off");
   chk_stage_split: assert property (tx_held_low |-> ##1 (second_attenuator_stage == 5'h1F || first_attenuator_stage == 5'h00))
      else $error("stage one before stage two full");
   chk_outputs_hold: assert property (quiet |-> $stable({first_attenuator_stage, second_attenuator_stage,
      first_amp_bias_trim, second_amp_bias_trim, first_amp_lin_off, second_amp_lin_off}))
      else $error("setting moved while idle");
   chk_release_zero: assert property ($fell(reset) |-> {first_attenuator_stage, second_attenuator_stage, first_amp_on} == 11'h000)
      else $error("outputs not clear after reset");
   chk_sdo_release: assert property (spi_cs_n [*5] |-> !spi_sdo_oe)
      else $error("sdo driven outside frame");
endmodule
`default_nettype wire

/* testbench/spi_host_model.sv */
// Serial host model: 24-bit frames, clock idle low, MSB first
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
   input wire logic clk,
   input wire logic spi_sdo,
   input wire logic spi_sdo_oe,
   output logic spi_cs_n,
   output logic spi_sclk,
   output logic spi_sdi,
   output logic done,
   output logic [7:0] rdata
);
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      spi_sdi = 1'b0;
      done = 1'b0;
      rdata = 8'h00;
   end
   task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wdat);
      logic [23:0] frame;
      frame = {rd, addr, wdat};
      @(negedge clk);
      spi_cs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spi_sdi = frame[i];
         repeat (6) @(negedge clk);
         // Undriven sdo reads unknown
         if (i < 8)
            rdata[i] = (spi_sdo_oe === 1'b1) ? spi_sdo : 1'bx;
         spi_sclk = 1'b1;
         repeat (6) @(negedge clk);
         spi_sclk = 1'b0;
      end
      repeat (2) @(negedge clk);
      spi_cs_n = 1'b1;
      done = rd;
      @(negedge clk);
      done = 1'b0;
      repeat (6) @(negedge clk);
   endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Top testbench of the gain-state register block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk, reset, txen, done, look, cs_n, sclk, sdi, sdo, sdo_oe, a1, a2, bg, lo1, lo2;
   logic [1:0] sel, lof;
   logic [4:0] st1, st2, lc1, lc2, m1, m2;
   logic [3:0] bt1, bt2;
   logic [5:0] att[4], c1;
   logic [7:0] trm[4], loff, rdata;
   logic [15:0] exp_q[$], got, want;
   int err_total, checked, cyc, seed;
   logic [14:0] adr[10] = '{15'h0102, 15'h0103, 15'h0104, 15'h0105, 15'h0106, 15'h010A, 15'h010B, 15'h0110,
      15'h0100, 15'h0120};
   logic [7:0] rst[10] = '{8'h3F, 8'h3F, 8'h55, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00};
   logic [7:0] msk[10] = '{8'h3F, 8'h3F, 8'hFF, 8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h77, 8'h00, 8'h00};
   logic [5:0] code[5] = '{6'h00, 6'h1F, 6'h20, 6'h21, 6'h3F};
   tx_vga_gain_state_registers tx_vga_gain_state_registers_inst (.clk(clk), .reset(reset), .spi_cs_n(cs_n),
      .spi_sclk(sclk), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .transmit_enable_pin(txen),
      .atten_state_select_pins(sel), .first_amp_on(a1), .second_amp_on(a2), .bias_gen_on(bg),
      .first_attenuator_stage(st1), .second_attenuator_stage(st2), .first_amp_bias_trim(bt1),
      .second_amp_bias_trim(bt2), .first_amp_linearity_code(lc1), .second_amp_linearity_code(lc2),
      .first_amp_lin_off(lo1), .second_amp_lin_off(lo2));
   spi_host_model host_inst (.clk(clk), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .spi_cs_n(cs_n),
      .spi_sclk(sclk), .spi_sdi(sdi), .done(done), .rdata(rdata));
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      host_inst.xfer(1'b0, a, d);
   endtask
   task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
      exp_q.push_back({8'h00, e});
      host_inst.xfer(1'b1, a, 8'h00);
   endtask
   // Pins reach outputs in three edges
   task automatic look_chk(input logic t, input logic [1:0] s, input logic [15:0] e);
      @(negedge clk);
      txen = t;
      sel = s;
      repeat (6) @(negedge clk);
      exp_q.push_back(e);
      look = 1'b1;
      @(negedge clk);
      look = 1'b0;
   endtask
   function automatic logic [15:0] split(input logic [5:0] c, input logic [1:0] f, input logic [3:0] t);
      return {c[5] ? c[4:0] : 5'h00, c[5] ? 5'h1F : c[4:0], f, t};
   endfunction
   task automatic test_done;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) begin
      if (done === 1'b1 || look === 1'b1) begin
         got = (look === 1'b1) ? {st1, st2, lo1, lo2, bt1} : {8'h00, rdata};
         want = exp_q.pop_front();
         checked++;
         if (got !== want) begin
            err_total++;
            $display("[FAIL] t=%0t got %h want %h", $time, got, want);
         end
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         test_done;
      end
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      seed = 57;
      reset = 1'b1;
      txen = 1'b1;
      sel = 2'b00;
      look = 1'b0;
      repeat (5) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 10; i++)
         rd_chk(adr[i], rst[i]);
      $display("reset value test done");
      for (int i = 0; i < 10; i++) begin
         if (i != 8) begin
            wr(adr[i], 8'hFF);
            rd_chk(adr[i], msk[i]);
         end
      end
      $display("reserved bit test done");
      for (int k = 0; k < 5; k++) begin
         loff = 8'($random(seed)) & 8'h77;
         c1 = 6'($random(seed));
         wr(15'h0110, loff);
         wr(15'h0103, {2'b00, c1});
         for (int s = 0; s < 4; s++) begin
            att[s] = (s == 0) ? code[k] : 6'($random(seed));
            trm[s] = 8'($random(seed));
            wr((s == 0) ? 15'h0102 : 15'(32'h0113 + s), {2'b00, att[s]});
            wr((s == 0) ? 15'h0104 : 15'(32'h0110 + s), trm[s]);
         end
         for (int s = 0; s < 4; s++) begin
            lof = (s == 0) ? 2'b00 : {loff[s - 1], loff[s + 3]};
            look_chk(1'b1, s[1:0], split(att[s], lof, trm[s][3:0]));
            look_chk(1'b0, s[1:0], split(c1, 2'b00, trm[s][3:0]));
         end
      end
      $display("state selection test done");
      m1 = 5'($random(seed));
      m2 = 5'($random(seed));
      wr(15'h0100, 8'h87);
      wr(15'h010A, {3'b000, m1});
      wr(15'h010B, {3'b000, m2});
      look_chk(1'b1, 2'b00, {m1, m2, 2'b00, trm[0][3:0]});
      wr(15'h0100, 8'h07);
      $display("manual mode test done");
      test_done;
   end
endmodule
bind tx_vga_gain_state_registers tx_vga_chk tx_vga_chk_inst (.*);
`default_nettype wire
